// >>> dv/pkrs_host_model.sv
/* serial master model for the packet buffer link.
   assumes one caller of xfer at a time. */
module pkrs_host_model (
    output logic      o_sck,
    output logic      o_cs_b,
    output logic      o_mosi,
    input  wire logic i_miso
);
    timeunit 1ns;
    timeprecision 1ps;
    logic lclk = 1'b0;
    // offset so link edges never meet core clock edges
    initial begin
        #1.3;
        forever #7.5 lclk = ~lclk;
    end
    initial begin
        o_sck = 1'b0;
        o_cs_b = 1'b1;
        o_mosi = 1'b0;
    end
    // 75 ns half period keeps sck near 6.7 MHz
    task automatic bits(input logic [15:0] v, input int n, inout logic [15:0] r);
        for (int i = n - 1; i >= 0; i--) begin
            o_mosi <= v[i]; // changes with the falling edge, msb first
            repeat (5) @(posedge lclk);
            o_sck <= 1'b1;
            r = {r[14:0], i_miso};
            repeat (5) @(posedge lclk);
            o_sck <= 1'b0;
        end
    endtask
    // no low-power state is modelled, so buffer access is always allowed
    task automatic xfer(input logic [7:0] h, input int n, input logic [15:0] d,
                        output logic [15:0] r);
        @(posedge lclk) o_cs_b <= 1'b0; // low for the whole frame
        bits({8'h00, h}, 8, r);
        for (int k = 0; k < n; k++)
            bits(d + 16'(k), 16, r); // whole words only
        repeat (5) @(posedge lclk);
        o_cs_b <= 1'b1;
        o_mosi <= ~o_mosi; // released line must not hold its last level
        repeat (10) @(posedge lclk);
    endtask
endmodule

// >>> dv/test_packet_ram_spi_access.sv
/* self-checking bench for the packet buffer serial access block.
   assumes the host model is compiled first. */
module test_packet_ram_spi_access;
    timeunit 1ns;
    timeprecision 1ps;
    logic             i_core_clk = 1'b0;
    logic             i_rst_b = 1'b0;
    logic [5:0]       i_tx_rd_addr = 6'h00;
    logic             sck, cs_b, mosi, miso, irq_b, swr, sel;
    logic [6:0]       len;
    logic [15:0]      txd, r;
    logic             busy = 1'b0;
    logic [5:0]       rxa;
    int               n_fail = 0;
    int               n_compared = 0;
    wire logic [15:0] st = {irq_b, swr, sel, len, 6'h00};
    initial forever #2.5 i_core_clk = ~i_core_clk;
    pkrs_spi_access pkrs_spi_access_i (
        .i_core_clk, .i_rst_b, .i_spi_clk(sck), .i_spi_cs_b(cs_b), .i_spi_mosi(mosi),
        .o_spi_miso(miso), .o_irq_b(irq_b), .o_sw_reset(swr), .o_tx_length(len),
        .o_second_buffer_choose(sel), .i_tx_rd_addr, .o_tx_rd_data(txd),
        .o_rx_rd_addr(rxa), .i_rx_rd_data({10'h154, rxa}), .i_tx_active(busy),
        .i_tx_ram_req(busy), .i_rx_active(busy), .i_rx_ram_req(busy));
    pkrs_host_model pkrs_host_model_i (.o_sck(sck), .o_cs_b(cs_b), .o_mosi(mosi), .i_miso(miso));
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic x(input logic [7:0] h, input int n, input logic [15:0] d);
        pkrs_host_model_i.xfer(h, n, d, r);
    endtask
    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        @(posedge i_core_clk) i_tx_rd_addr <= a;
        repeat (2) @(posedge i_core_clk);
        @(negedge i_core_clk) cmp(txd, e);
    endtask
    task automatic t_ctl;
        x(8'h03, 1, 16'h8005); // length before buffer data
        cmp(st, 16'ha140);
        $display("ctl done");
    endtask
    task automatic t_buf;
        x(8'h02, 3, 16'ha5a0);
        rd(6'h02, 16'ha5a2);
        x(8'h02, 1, 16'h1234);
        rd(6'h00, 16'h1234);
        rd(6'h01, 16'ha5a1);
        $display("buf done");
    endtask
    task automatic t_ovr;
        x(8'h02, 65, 16'h0000);
        cmp(st, 16'ha140);
        rd(6'h00, 16'h0000);
        x(8'h05, 1, 16'h1000);
        cmp(st, 16'h2140);
        x(8'ha4, 1, 16'h0000);
        cmp(r, 16'h4000);
        cmp(st, 16'ha140);
        $display("ovr done");
    endtask
    task automatic t_col;
        @(posedge i_core_clk) busy <= 1'b1;
        x(8'h02, 1, 16'h0000);
        x(8'ha4, 1, 16'h0000);
        cmp(r, 16'h2000);
        x(8'h81, 65, 16'h0000);
        cmp(r, 16'h553f);
        cmp(st, 16'h2140);
        @(posedge i_core_clk) busy <= 1'b0;
        x(8'h05, 1, 16'h0800);
        cmp(st, 16'h2140);
        x(8'ha4, 1, 16'h0000);
        cmp(r, 16'h6000);
        cmp(st, 16'ha140);
        $display("col done");
    endtask
    task automatic t_swr;
        x(8'h80, 1, 16'h0000);
        cmp(st, 16'ha140);
        fork
            x(8'h00, 1, 16'h0000);
            begin
                repeat (400) @(posedge i_core_clk);
                @(negedge i_core_clk);
                cmp(st, 16'hc000);
            end
        join
        cmp(st, 16'h8000);
        x(8'h03, 1, 16'h8000);
        rd(6'h3f, 16'h003f);
        $display("swr done");
    endtask
    task automatic stop_test;
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        cmp(st, 16'h8000);
        t_ctl();
        t_buf();
        t_ovr();
        t_col();
        t_swr();
        stop_test();
    end
    initial begin
        #450us;
        n_fail++;
        stop_test();
    end
endmodule

// >>> rtl/pkrs_params.svh
/*
 * Register offsets, field positions, reset values and timing counts of the packet buffer
 * serial access block.
 * Assumes it is included by bare name from design files; it holds definitions only.
 */
`ifndef PKRS_PARAMS_SVH
`define PKRS_PARAMS_SVH

// register offsets (6-bit register address field of the header byte)
`define PKRS_ADDR_SW_RESET   6'h00
`define PKRS_ADDR_RX_PORT    6'h01
`define PKRS_ADDR_TX_PORT    6'h02
`define PKRS_ADDR_TX_CTL     6'h03
`define PKRS_ADDR_IRQ_MASK   6'h05
`define PKRS_ADDR_IRQ_STAT   6'h24
`define PKRS_ADDR_LAST       6'h3f
`define PKRS_ADDR_WRAP       6'h03

// header and field positions
`define PKRS_HDR_READ_BIT    7
`define PKRS_HDR_ADDR_MSB    5
`define PKRS_CTL_SEL_BIT     15
`define PKRS_CTL_LEN_MSB     6
`define PKRS_STAT_OVR_BIT    14
`define PKRS_STAT_COL_BIT    13
`define PKRS_MASK_OVR_BIT    12
`define PKRS_MASK_COL_BIT    11

// reset values
`define PKRS_CTL_SEL_RESET   1'b0
`define PKRS_CTL_LEN_RESET   7'h00
`define PKRS_MASK_OVR_RESET  1'b0
`define PKRS_MASK_COL_RESET  1'b0

// buffer geometry and frame figures
`define PKRS_BUF_WORDS       64
`define PKRS_MAX_LEN_BYTES   127
`define PKRS_CRC_BYTES       2
`define PKRS_HDR_BITS        8
`define PKRS_WORD_BITS       16

// timing: fastest serial clock and core clock, both in MHz
`define PKRS_SCK_MAX_MHZ     8
`define PKRS_CORE_MHZ        200
// core cycles in the shortest serial half period (rounded down)
`define PKRS_HALF_SCK_CYC    ((`PKRS_CORE_MHZ) / (2 * `PKRS_SCK_MAX_MHZ))
// core cycles from the last serial edge of a unit to a fresh read word
`define PKRS_FETCH_LAT_CYC   4

`endif

// >>> rtl/pkrs_pkg.sv
/*
 * Types shared by the packet buffer serial access block.
 * Assumes nothing of its surroundings; constants live in pkrs_params.svh.
 */
package pkrs_pkg;

    typedef enum logic [1:0] {
        kind_hdr   = 2'b00,
        kind_reg   = 2'b01,
        kind_txbuf = 2'b10,
        kind_rxbuf = 2'b11
    } pkrs_kind_t;

    // link-side frame state, cleared whenever chip select is high
    typedef struct packed {
        logic [3:0]  cnt;
        logic        hdr_done;
        logic [15:0] shift;
    } pkrs_spi_frame_t;

    // link-side handover words, kept across chip select so the core can still read them
    typedef struct packed {
        logic [7:0]  hdr;
        logic [15:0] wdata;
        logic        tgl;
    } pkrs_spi_data_t;

    // falling-edge output stage
    typedef struct packed {
        logic [15:0] word;
        logic        miso;
    } pkrs_spi_out_t;

endpackage

// >>> rtl/pkrs_spi_access.sv
/*
 * Serial slave access to the transmit packet buffers, transmit control, error flags,
 * error masks and the software reset.
 * Assumes a mode 0, MSB-first master on i_spi_clk that holds chip select low for a whole
 * transaction and runs at most at 8 MHz; the transmit and receive logic live outside.
 */
`include "pkrs_params.svh"

// What this block does
// - receive buffer read past 64 words sets the overrun flag, status bit 14.
// - transmit buffer write past 64 words also sets the overrun flag.
// - overrun drives the interrupt only when mask bit 12 is set.
// - receive logic needing the buffer during a host read sets collision bit 13.
// - transmit logic needing the buffer during a host write sets collision flag.
// - collision drives the interrupt only when mask bit 11 is set.
// - reading interrupt status clears the error flags it reports.
// - buffer port burst keeps register address, steps buffer pointer once per word.
// - every buffer access starts at the lowest buffer word.
// - length is at most 127 bytes including 2 checksum bytes never stored.
// - control bit 15 picks the second transmit buffer, for access and sending.
// - writing address 0x00 resets the core logic and all register fields.
// - software reset acts like the reset pin but keeps buffer contents.
// - software reset starts after the write header to 0, holds until select high.
// - reading address 00 has no reset effect.
// - each buffer is 64 words of 16 bits, one word per data payload.
module pkrs_spi_access #(
    parameter int BUF_WORDS = `PKRS_BUF_WORDS,
    parameter int AW        = $clog2(BUF_WORDS)
) (
    input  wire logic          i_core_clk,
    input  wire logic          i_rst_b,
    input  wire logic          i_spi_clk,
    input  wire logic          i_spi_cs_b,
    input  wire logic          i_spi_mosi,
    output logic               o_spi_miso,
    output logic               o_irq_b,
    output logic               o_sw_reset,
    output logic [6:0]         o_tx_length,
    output logic               o_second_buffer_choose,
    input  wire logic [AW-1:0] i_tx_rd_addr,
    output logic [15:0]        o_tx_rd_data,
    output logic [AW-1:0]      o_rx_rd_addr,
    input  wire logic [15:0]   i_rx_rd_data,
    input  wire logic          i_tx_active,
    input  wire logic          i_tx_ram_req,
    input  wire logic          i_rx_active,
    input  wire logic          i_rx_ram_req
);
    typedef struct packed {
        logic                   cs_b_s1;
        logic                   cs_b_s2;
        logic                   tg_s1;
        logic                   tg_s2;
        logic                   tg_seen;
        pkrs_pkg::pkrs_kind_t   kind;
        logic                   rd_mode;
        logic [5:0]             addr;
        logic [AW:0]            ptr;
        logic                   sw_rst;
        logic                   tx_sel;
        logic [6:0]             tx_len;
        logic                   m_ovr;
        logic                   m_col;
        logic                   st_ovr;
        logic                   st_col;
        logic [15:0]            rd_word;
        logic [AW-1:0]          rx_addr;
        logic                   irq_b;
        logic [15:0]            tx_rd_data;
    } pkrs_core_t;

    generate
        if (BUF_WORDS != (1 << AW) || BUF_WORDS > `PKRS_BUF_WORDS) begin : g_bad_words
            $error("pkrs_spi_access: buffer depth must be a power of two up to 64");
        end
        if (`PKRS_HALF_SCK_CYC <= `PKRS_FETCH_LAT_CYC) begin : g_bad_timing
            $error("pkrs_spi_access: core clock too slow for the serial clock");
        end
    endgenerate

    // link domain
    pkrs_pkg::pkrs_spi_frame_t fr;
    pkrs_pkg::pkrs_spi_frame_t next_fr;
    pkrs_pkg::pkrs_spi_data_t  dq;
    pkrs_pkg::pkrs_spi_data_t  next_dq;
    pkrs_pkg::pkrs_spi_out_t   oq;
    pkrs_pkg::pkrs_spi_out_t   next_oq;
    logic                      spi_arst_b;
    logic [15:0]               spi_sh;

    // core domain
    pkrs_core_t    st;
    pkrs_core_t    next_st;
    logic          evt;
    logic          set_ovr;
    logic          set_col;
    logic          fetch_stat;
    logic          we0;
    logic          we1;
    logic [AW-1:0] fetch_addr;
    logic [15:0]   rd0_a;
    logic [15:0]   rd1_a;
    logic [15:0]   rd0_b;
    logic [15:0]   rd1_b;
    logic          hdr_rd;
    logic [5:0]    hdr_a;
    logic [5:0]    addr_step;
    logic          is_buf;

    // a frame ends with chip select, and the link clock stands still then
    assign spi_arst_b = i_rst_b & ~i_spi_cs_b;
    assign spi_sh     = {fr.shift[14:0], i_spi_mosi};

    always_comb begin
        next_fr       = fr;
        next_dq       = dq;
        next_fr.shift = spi_sh;
        if (!fr.hdr_done) begin
            if (fr.cnt == 4'(`PKRS_HDR_BITS - 1)) begin
                // header complete on the eighth rising edge
                next_dq.hdr      = spi_sh[7:0];
                next_dq.tgl      = ~dq.tgl;
                next_fr.hdr_done = 1'b1;
                next_fr.cnt      = 4'h0;
            end else begin
                next_fr.cnt = fr.cnt + 4'h1;
            end
        end else if (fr.cnt == 4'(`PKRS_WORD_BITS - 1)) begin
            // one 16-bit payload maps onto one buffer word
            next_dq.wdata = spi_sh;
            next_dq.tgl   = ~dq.tgl;
            next_fr.cnt   = 4'h0;
        end else begin
            next_fr.cnt = fr.cnt + 4'h1;
        end
    end

    always_ff @(posedge i_spi_clk or negedge spi_arst_b) begin
        if (!spi_arst_b) begin
            fr <= '0;
        end else begin
            fr <= next_fr;
        end
    end

    // kept past chip select: the core reads the last word a few cycles after the frame
    always_ff @(posedge i_spi_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            dq <= '0;
        end else begin
            dq <= next_dq;
        end
    end

    // rd_word is quasi-static: the core refreshes it within a few cycles of a unit end,
    // well inside the shortest serial half period, and it then stands for a whole word
    always_comb begin
        next_oq = oq;
        if (!fr.hdr_done) begin
            next_oq.miso = 1'b0;
        end else if (fr.cnt == 4'h0) begin
            next_oq.miso = st.rd_word[15];
            next_oq.word = {st.rd_word[14:0], 1'b0};
        end else begin
            next_oq.miso = oq.word[15];
            next_oq.word = {oq.word[14:0], 1'b0};
        end
    end

    always_ff @(negedge i_spi_clk or negedge spi_arst_b) begin
        if (!spi_arst_b) begin
            oq <= '0;
        end else begin
            oq <= next_oq;
        end
    end

    assign o_spi_miso = oq.miso;

    // core domain
    pkrs_word_ram #(.WORDS(BUF_WORDS), .WIDTH(16)) u_ram0 (
        .i_clk     (i_core_clk),
        .i_we      (we0),
        .i_waddr   (st.ptr[AW-1:0]),
        .i_wdata   (dq.wdata),
        .i_raddr_a (fetch_addr),
        .o_rdata_a (rd0_a),
        .i_raddr_b (i_tx_rd_addr),
        .o_rdata_b (rd0_b)
    );

    pkrs_word_ram #(.WORDS(BUF_WORDS), .WIDTH(16)) u_ram1 (
        .i_clk     (i_core_clk),
        .i_we      (we1),
        .i_waddr   (st.ptr[AW-1:0]),
        .i_wdata   (dq.wdata),
        .i_raddr_a (fetch_addr),
        .o_rdata_a (rd1_a),
        .i_raddr_b (i_tx_rd_addr),
        .o_rdata_b (rd1_b)
    );

    function automatic logic [15:0] reg_value(input logic [5:0] a, input pkrs_core_t s);
        logic [15:0] v;
        v = 16'h0000;
        unique case (a)
            `PKRS_ADDR_TX_CTL: begin
                v[`PKRS_CTL_SEL_BIT]         = s.tx_sel;
                v[`PKRS_CTL_LEN_MSB:0]       = s.tx_len;
            end
            `PKRS_ADDR_IRQ_MASK: begin
                v[`PKRS_MASK_OVR_BIT]        = s.m_ovr;
                v[`PKRS_MASK_COL_BIT]        = s.m_col;
            end
            `PKRS_ADDR_IRQ_STAT: begin
                v[`PKRS_STAT_OVR_BIT]        = s.st_ovr;
                v[`PKRS_STAT_COL_BIT]        = s.st_col;
            end
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

    assign evt        = st.tg_s2 != st.tg_seen;
    assign hdr_rd     = dq.hdr[`PKRS_HDR_READ_BIT];
    assign hdr_a      = dq.hdr[`PKRS_HDR_ADDR_MSB:0];
    assign addr_step  = (st.addr == `PKRS_ADDR_LAST) ? `PKRS_ADDR_WRAP : st.addr + 6'h01;
    assign is_buf     = (st.kind == pkrs_pkg::kind_txbuf) || (st.kind == pkrs_pkg::kind_rxbuf);
    // next word to show: word 0 after the header, else the word after the current one
    assign fetch_addr = (st.kind == pkrs_pkg::kind_hdr) ? '0 : st.ptr[AW-1:0] + 1'b1;

    always_comb begin
        next_st            = st;
        we0                = 1'b0;
        we1                = 1'b0;
        set_ovr            = 1'b0;
        fetch_stat         = 1'b0;
        next_st.cs_b_s1    = i_spi_cs_b;
        next_st.cs_b_s2    = st.cs_b_s1;
        next_st.tg_s1      = dq.tgl;
        next_st.tg_s2      = st.tg_s1;
        next_st.tg_seen    = st.tg_s2;
        // transmit logic reads the chosen buffer too
        next_st.tx_rd_data = st.tx_sel ? rd1_b : rd0_b;
        set_col = (st.kind == pkrs_pkg::kind_rxbuf && st.rd_mode && i_rx_active
                   && i_rx_ram_req)
                | (st.kind == pkrs_pkg::kind_txbuf && !st.rd_mode && i_tx_active
                   && i_tx_ram_req);
        if (evt && st.kind == pkrs_pkg::kind_hdr) begin
            next_st.rd_mode = hdr_rd;
            next_st.addr    = hdr_a;
            next_st.ptr     = '0;
            next_st.rx_addr = '0;
            if (hdr_a == `PKRS_ADDR_TX_PORT) begin
                next_st.kind    = pkrs_pkg::kind_txbuf;
                next_st.rd_word = st.tx_sel ? rd1_a : rd0_a;
            end else if (hdr_a == `PKRS_ADDR_RX_PORT) begin
                // the first receive word carries no buffer data
                next_st.kind    = pkrs_pkg::kind_rxbuf;
                next_st.rd_word = 16'h0000;
            end else begin
                next_st.kind    = pkrs_pkg::kind_reg;
                next_st.rd_word = reg_value(hdr_a, st);
                fetch_stat      = hdr_rd && (hdr_a == `PKRS_ADDR_IRQ_STAT);
            end
            // only a write header starts the reset; a read of 00 does nothing
            if (!hdr_rd && hdr_a == `PKRS_ADDR_SW_RESET) begin
                next_st.sw_rst = 1'b1;
            end
        end else if (evt) begin
            if (is_buf) begin
                // register address stays, buffer pointer steps once per word
                set_ovr = st.ptr[AW];
                if (!st.ptr[AW]) begin
                    next_st.ptr = st.ptr + 1'b1;
                end
            end
            if (st.kind == pkrs_pkg::kind_txbuf && !st.rd_mode && !st.ptr[AW]) begin
                we0 = !st.tx_sel;
                we1 = st.tx_sel;
            end
            if (st.kind == pkrs_pkg::kind_reg) begin
                next_st.addr = addr_step;
            end
            if (!st.rd_mode && st.kind == pkrs_pkg::kind_reg) begin
                if (st.addr == `PKRS_ADDR_TX_CTL) begin
                    next_st.tx_sel = dq.wdata[`PKRS_CTL_SEL_BIT];
                    // 7-bit field caps length at 127, checksum not buffered
                    next_st.tx_len = dq.wdata[`PKRS_CTL_LEN_MSB:0];
                end
                if (st.addr == `PKRS_ADDR_IRQ_MASK) begin
                    next_st.m_ovr = dq.wdata[`PKRS_MASK_OVR_BIT];
                    next_st.m_col = dq.wdata[`PKRS_MASK_COL_BIT];
                end
            end
            if (st.rd_mode) begin
                unique case (st.kind)
                    pkrs_pkg::kind_txbuf: next_st.rd_word = st.tx_sel ? rd1_a : rd0_a;
                    pkrs_pkg::kind_rxbuf: begin
                        next_st.rd_word = i_rx_rd_data;
                        next_st.rx_addr = st.rx_addr + 1'b1;
                    end
                    pkrs_pkg::kind_reg: begin
                        next_st.rd_word = reg_value(addr_step, st);
                        fetch_stat      = (addr_step == `PKRS_ADDR_IRQ_STAT);
                    end
                    pkrs_pkg::kind_hdr: next_st.rd_word = st.rd_word;
                endcase
            end
        end else if (st.cs_b_s2) begin
            // events win over the frame end so a late last word is not lost
            next_st.kind    = pkrs_pkg::kind_hdr;
            next_st.ptr     = '0;
            next_st.rx_addr = '0;
            next_st.sw_rst  = 1'b0;
        end
        // set wins over the clear by read
        next_st.st_ovr = (st.st_ovr & ~fetch_stat) | set_ovr;
        next_st.st_col = (st.st_col & ~fetch_stat) | set_col;
        // defaults while software reset holds; buffers untouched
        if (st.sw_rst) begin
            next_st.tx_sel = `PKRS_CTL_SEL_RESET;
            next_st.tx_len = `PKRS_CTL_LEN_RESET;
            next_st.m_ovr  = `PKRS_MASK_OVR_RESET;
            next_st.m_col  = `PKRS_MASK_COL_RESET;
            next_st.st_ovr = 1'b0;
            next_st.st_col = 1'b0;
        end
        next_st.irq_b = ~((st.st_ovr & st.m_ovr)
                        | (st.st_col & st.m_col));
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st         <= '0;
            st.cs_b_s1 <= 1'b1;
            st.cs_b_s2 <= 1'b1;
            st.irq_b   <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign o_irq_b                = st.irq_b;
    assign o_sw_reset             = st.sw_rst;
    assign o_tx_length            = st.tx_len;
    assign o_second_buffer_choose = st.tx_sel;
    assign o_tx_rd_data           = st.tx_rd_data;
    assign o_rx_rd_addr           = st.rx_addr;

    // checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    chk_ovr_rx_past: assert property (
        (evt && st.kind == pkrs_pkg::kind_rxbuf && st.ptr[AW] && !st.sw_rst) |=> st.st_ovr)
        else $error("receive overrun flag not set");

    chk_ovr_tx_past: assert property (
        (evt && st.kind == pkrs_pkg::kind_txbuf && st.ptr[AW] && !st.sw_rst)
        |=> st.st_ovr ##1 (!st.irq_b || !st.m_ovr))
        else $error("transmit overrun flag or its request missing");

    chk_irq_ovr_gate: assert property (
        (st.st_ovr && !st.m_ovr && !(st.st_col && st.m_col)) |=> st.irq_b)
        else $error("overrun request raised while masked");

    chk_col_rx: assert property (
        (st.kind == pkrs_pkg::kind_rxbuf && st.rd_mode && i_rx_active && i_rx_ram_req
         && !st.sw_rst) |=> st.st_col)
        else $error("receive collision not flagged");

    chk_col_tx: assert property (
        (st.kind == pkrs_pkg::kind_txbuf && !st.rd_mode && i_tx_active && i_tx_ram_req
         && !st.sw_rst) |=> st.st_col)
        else $error("transmit collision not flagged");

    chk_irq_col_gate: assert property (
        (st.st_col && st.m_col) |=> !st.irq_b)
        else $error("unmasked collision gave no request");

    chk_stat_clear: assert property (
        (fetch_stat && !set_ovr && !set_col) |=> (!st.st_ovr && !st.st_col))
        else $error("status read did not clear flags");

    chk_ptr_step: assert property (
        (evt && st.kind == pkrs_pkg::kind_txbuf && !st.ptr[AW])
        |=> (st.ptr == $past(st.ptr) + 1'b1) && $stable(st.addr))
        else $error("buffer pointer did not step by one word");

    chk_ptr_start: assert property (
        (evt && st.kind == pkrs_pkg::kind_hdr) |=> (st.ptr == '0))
        else $error("buffer access not started at word zero");

    chk_bank_pick: assert property (
        (we0 || we1) |-> (we1 == st.tx_sel) && !(we0 && we1))
        else $error("write went to the wrong buffer");

    chk_swrst_defaults: assert property (
        st.sw_rst |=> (st.tx_len == `PKRS_CTL_LEN_RESET) && !st.m_ovr && !st.st_ovr)
        else $error("software reset left a field set");

    chk_swrst_hold: assert property (
        (st.sw_rst && !st.cs_b_s2) |=> st.sw_rst)
        else $error("software reset dropped before select rose");

    chk_rd_zero_quiet: assert property (
        (evt && st.kind == pkrs_pkg::kind_hdr && hdr_rd && !st.sw_rst) |=> !st.sw_rst)
        else $error("read of address zero caused a reset");

    chk_drop_past_end: assert property (
        (st.ptr[AW]) |-> !(we0 || we1))
        else $error("write past last buffer word stored");

    chk_hdr_bits: assert property (
        @(posedge i_spi_clk) disable iff (!spi_arst_b)
        (!fr.hdr_done && fr.cnt == 4'h7) |=> fr.hdr_done && (fr.cnt == 4'h0))
        else $error("header not taken after eight bits");

    cov_tx_write: cover property (evt && st.kind == pkrs_pkg::kind_txbuf && !st.rd_mode);
    cov_sw_reset: cover property ($rose(st.sw_rst) ##[1:1000] $fell(st.sw_rst));
    cov_overrun:  cover property ($rose(st.st_ovr));
    cov_stat_rd:  cover property (fetch_stat && st.st_ovr);
endmodule

// >>> rtl/pkrs_word_ram.sv
/*
 * One packet buffer: a word array with one write port and two combinational read ports.
 * Assumes the writer and both readers run on the clock given here; contents have no reset.
 */
module pkrs_word_ram #(
    parameter int WORDS = 64,
    parameter int WIDTH = 16
) (
    input  wire logic                     i_clk,
    input  wire logic                     i_we,
    input  wire logic [$clog2(WORDS)-1:0] i_waddr,
    input  wire logic [WIDTH-1:0]         i_wdata,
    input  wire logic [$clog2(WORDS)-1:0] i_raddr_a,
    output logic      [WIDTH-1:0]         o_rdata_a,
    input  wire logic [$clog2(WORDS)-1:0] i_raddr_b,
    output logic      [WIDTH-1:0]         o_rdata_b
);
    logic [WIDTH-1:0] mem [WORDS];

    generate
        if (WORDS < 2 || WIDTH < 1) begin : g_bad
            $error("pkrs_word_ram: unsupported geometry");
        end
    endgenerate

    // no reset: contents must survive a software reset
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    assign o_rdata_a = mem[i_raddr_a];
    assign o_rdata_b = mem[i_raddr_b];
endmodule
